// ==== prseq_regs.svh ====
`ifndef PRSEQ_REGS_SVH
`define PRSEQ_REGS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define PRSEQ_CLK_PERIOD_NS 40
`define PRSEQ_PWR_DELAY_MS 47
// least times round up to whole cycles
`define PRSEQ_PWR_DELAY_CYC \
   (((`PRSEQ_PWR_DELAY_MS * 1000000) + `PRSEQ_CLK_PERIOD_NS - 1) / `PRSEQ_CLK_PERIOD_NS)
`define PRSEQ_OK_DELAY_US 100
`define PRSEQ_OK_DELAY_CYC \
   (((`PRSEQ_OK_DELAY_US * 1000) + `PRSEQ_CLK_PERIOD_NS - 1) / `PRSEQ_CLK_PERIOD_NS)
`define PRSEQ_RST_PULSE_NS 400
`define PRSEQ_RST_PULSE_CYC \
   ((`PRSEQ_RST_PULSE_NS + `PRSEQ_CLK_PERIOD_NS - 1) / `PRSEQ_CLK_PERIOD_NS)
`define PRSEQ_TMR_W 21

// ----------------------------------------
// start-up values
// ----------------------------------------
`define PRSEQ_NOP_COUNT 4'ha
`define PRSEQ_INIT_SP 16'h00fe
`define PRSEQ_INIT_STAT_WORD 16'h00e0
`define PRSEQ_START_RST 16'h0000
`define PRSEQ_MODE_RST 16'h0000
`define PRSEQ_CSR_RST 16'h0000

// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define PRSEQ_REG_CTRL 3'h0
`define PRSEQ_REG_STATUS 3'h1
`define PRSEQ_REG_CSR_A 3'h2
`define PRSEQ_REG_CSR_B 3'h3
`define PRSEQ_REG_CSR_C 3'h4
`define PRSEQ_REG_LCS_D 3'h5
`define PRSEQ_REG_MODE 3'h6
`define PRSEQ_REG_START 3'h7
`define PRSEQ_CTRL_STANDALONE 0
`define PRSEQ_CTRL_RESET 1

`endif

// ==== prseq_pkg.sv ====
`default_nettype none
`include "prseq_regs.svh"

package prseq_pkg;

   typedef logic [`PRSEQ_TMR_W-1:0] prseq_tmr_t;

   typedef enum logic [3:0] {
      ST_PWR_DELAY,
      ST_CLEAR_WAIT,
      ST_OK_DELAY,
      ST_NOP,
      ST_LOAD,
      ST_PRIO_IN,
      ST_RUN,
      ST_RST_CLEAR
   } prseq_state_t;

   // initial register image handed to the core
   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] sp;
      logic [15:0] stat_word;
   } prseq_load_t;

   // status register layout
   typedef struct packed {
      logic [3:0] state;
      logic [3:0] nop_count;
      logic standalone;
      logic fetch_enable;
      logic bus_clear;
      logic power_up;
      logic [3:0] spare;
   } prseq_status_t;

endpackage

`default_nettype wire

// ==== prseq_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

// loadable down counter; load has priority, so the owner drives it during reset
module prseq_timer (
   input wire logic sys_clk,
   input wire logic load,
   input wire prseq_pkg::prseq_tmr_t load_value,
   output logic done
);

   prseq_pkg::prseq_tmr_t cnt;

   // ----------------------------------------
   // count down and stop at zero
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (load) begin
         cnt <= load_value;
      end else if (cnt != '0) begin
         cnt <= cnt - 1'b1;
      end
   end

   assign done = (cnt == '0) && !load;

endmodule

`default_nettype wire

// ==== prseq_strobe_counter.sv ====
`timescale 1ns/1ps
`default_nettype none

// counts microcycle strobes and saturates at the target
module prseq_strobe_counter (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clear,
   input wire logic strobe,
   input wire logic [3:0] target,
   output logic [3:0] count,
   output logic done
);

   // ----------------------------------------
   // strobe count
   // ----------------------------------------
   // saturation keeps a late strobe from pushing the count past target
   always_ff @(posedge sys_clk) begin
      if (sys_rst || clear) begin
         count <= 4'h0;
      end else if (strobe && (count != target)) begin
         count <= count + 4'h1;
      end
   end

   assign done = (count == target);

endmodule

`default_nettype wire

// ==== prseq_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "prseq_regs.svh"

module prseq_sequencer #(
   parameter int PWR_DELAY_CYCLES = `PRSEQ_PWR_DELAY_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [2:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic supply_good,
   input wire logic dc_ok_n,
   input wire logic power_ok_n,
   input wire logic power_up_trigger_n,
   input wire logic power_up_force,
   input wire logic clock_out_strobe,
   input wire logic reset_instr,
   input wire logic [15:0] local_addr_data_bus,
   input wire logic [3:0] irq_req,
   input wire logic [3:0] irq_ack,
   output logic power_up_input,
   output logic bus_clear_output_n,
   output logic serial_line_clear,
   output logic backplane_xcvr_en,
   output logic local_xcvr_en,
   output logic [3:0] irq_to_core,
   output logic nop_cycle,
   output logic load_regs,
   output prseq_pkg::prseq_load_t load_values,
   output logic assert_priority_in_cycle,
   output logic priority_in_strobe,
   output logic fetch_enable,
   output logic txn_abort,
   output logic [15:0] mode_reg
);

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   // states in which the board's control logic is held in clear
   function automatic logic is_clearing(input prseq_pkg::prseq_state_t s);
      return (s == prseq_pkg::ST_CLEAR_WAIT) || (s == prseq_pkg::ST_OK_DELAY) ||
             (s == prseq_pkg::ST_RST_CLEAR);
   endfunction

   // timer length for states that wait on the timer
   function automatic prseq_pkg::prseq_tmr_t timer_len(input prseq_pkg::prseq_state_t s);
      case (s)
         prseq_pkg::ST_OK_DELAY: timer_len = prseq_pkg::prseq_tmr_t'(`PRSEQ_OK_DELAY_CYC);
         prseq_pkg::ST_RST_CLEAR: timer_len = prseq_pkg::prseq_tmr_t'(`PRSEQ_RST_PULSE_CYC);
         default: timer_len = prseq_pkg::prseq_tmr_t'(PWR_DELAY_CYCLES);
      endcase
   endfunction

   prseq_pkg::prseq_state_t state;
   prseq_pkg::prseq_state_t next_state;
   logic pwr_up_ff;
   logic pwr_up_drop;
   logic standalone;
   logic sw_reset;
   logic timer_load;
   logic timer_done;
   logic nop_done;
   logic [3:0] nop_count;
   logic pi_done;
   logic [3:0] irq_pend;
   logic [15:0] csr_a;
   logic [15:0] csr_b;
   logic [15:0] csr_c;
   logic [15:0] local_control_status_d;
   logic [15:0] start_addr;
   prseq_pkg::prseq_status_t status;

   assign sw_reset = reg_wr && (reg_addr == `PRSEQ_REG_CTRL) && reg_wdata[`PRSEQ_CTRL_RESET];
   assign pi_done = (state == prseq_pkg::ST_PRIO_IN) && priority_in_strobe && clock_out_strobe;

   // ----------------------------------------
   // sequence control
   // ----------------------------------------
   // a forced power-up overrides every state except the initial supply wait
   always_comb begin
      next_state = state;
      case (state)
         prseq_pkg::ST_PWR_DELAY: begin
            if (timer_done && supply_good) begin
               next_state = prseq_pkg::ST_CLEAR_WAIT;
            end
         end
         prseq_pkg::ST_CLEAR_WAIT: begin
            if (standalone && !power_up_trigger_n) begin
               next_state = prseq_pkg::ST_NOP;
            end else if (!standalone && !dc_ok_n && !power_ok_n) begin
               next_state = prseq_pkg::ST_OK_DELAY;
            end
         end
         prseq_pkg::ST_OK_DELAY: begin
            if (dc_ok_n || power_ok_n) begin
               next_state = prseq_pkg::ST_CLEAR_WAIT;
            end else if (timer_done) begin
               next_state = prseq_pkg::ST_NOP;
            end
         end
         prseq_pkg::ST_NOP: begin
            if (nop_done) begin
               next_state = prseq_pkg::ST_LOAD;
            end
         end
         prseq_pkg::ST_LOAD: next_state = prseq_pkg::ST_PRIO_IN;
         prseq_pkg::ST_PRIO_IN: begin
            if (pi_done) begin
               next_state = prseq_pkg::ST_RUN;
            end
         end
         prseq_pkg::ST_RUN: begin
            if (reset_instr || sw_reset) begin
               next_state = prseq_pkg::ST_RST_CLEAR;
            end
         end
         prseq_pkg::ST_RST_CLEAR: begin
            if (timer_done) begin
               next_state = prseq_pkg::ST_PRIO_IN;
            end
         end
         default: next_state = prseq_pkg::ST_PWR_DELAY;
      endcase
      if (power_up_force && (state != prseq_pkg::ST_PWR_DELAY)) begin
         next_state = prseq_pkg::ST_CLEAR_WAIT;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= prseq_pkg::ST_PWR_DELAY;
      end else begin
         state <= next_state;
      end
   end

   // timer restarts while the supply is absent so the delay runs from its arrival
   assign timer_load = sys_rst ||
                       ((state == prseq_pkg::ST_PWR_DELAY) && !supply_good) ||
                       ((next_state != state) && ((next_state == prseq_pkg::ST_OK_DELAY) ||
                                                  (next_state == prseq_pkg::ST_RST_CLEAR)));

   prseq_timer u_timer (
      .sys_clk(sys_clk),
      .load(timer_load),
      .load_value(timer_len(sys_rst ? prseq_pkg::ST_PWR_DELAY : next_state)),
      .done(timer_done)
   );

   prseq_strobe_counter u_nop_counter (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clear(state != prseq_pkg::ST_NOP),
      .strobe(clock_out_strobe),
      .target(`PRSEQ_NOP_COUNT),
      .count(nop_count),
      .done(nop_done)
   );

   // ----------------------------------------
   // power-up flip-flop
   // ----------------------------------------
   // set wins over the release so a new force is never lost
   assign pwr_up_drop = (next_state == prseq_pkg::ST_NOP) &&
                        ((state == prseq_pkg::ST_OK_DELAY) || (state == prseq_pkg::ST_CLEAR_WAIT));

   always_ff @(posedge sys_clk) begin
      if (sys_rst || power_up_force) begin
         pwr_up_ff <= 1'b1;
      end else if (pwr_up_drop) begin
         pwr_up_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         txn_abort <= 1'b0;
      end else begin
         txn_abort <= power_up_force && !pwr_up_ff;
      end
   end

   // ----------------------------------------
   // board-level outputs
   // ----------------------------------------
   // all driven from next_state so they line up with the state register
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bus_clear_output_n <= 1'b1;
         backplane_xcvr_en <= 1'b0;
         local_xcvr_en <= 1'b0;
         serial_line_clear <= 1'b0;
         nop_cycle <= 1'b0;
         assert_priority_in_cycle <= 1'b0;
         fetch_enable <= 1'b0;
      end else begin
         bus_clear_output_n <= !is_clearing(next_state);
         backplane_xcvr_en <= !is_clearing(next_state) && !power_up_force;
         local_xcvr_en <= !is_clearing(next_state) && !power_up_force;
         serial_line_clear <= is_clearing(next_state) &&
                              (next_state != prseq_pkg::ST_RST_CLEAR);
         nop_cycle <= (next_state == prseq_pkg::ST_NOP);
         assert_priority_in_cycle <= (next_state == prseq_pkg::ST_PRIO_IN);
         fetch_enable <= (next_state == prseq_pkg::ST_RUN);
      end
   end

   // priority-in stands high for one whole microcycle of the priority-in cycle
   always_ff @(posedge sys_clk) begin
      if (sys_rst || (state != prseq_pkg::ST_PRIO_IN) || power_up_force) begin
         priority_in_strobe <= 1'b0;
      end else if (clock_out_strobe) begin
         priority_in_strobe <= !priority_in_strobe;
      end
   end

   // ----------------------------------------
   // initial register load
   // ----------------------------------------
   // the reset-instruction path never reaches ST_LOAD, so status word is kept
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         load_regs <= 1'b0;
         load_values <= '0;
      end else begin
         load_regs <= (next_state == prseq_pkg::ST_LOAD) && (state != prseq_pkg::ST_LOAD);
         if (next_state == prseq_pkg::ST_LOAD) begin
            load_values.pc <= start_addr;
            load_values.sp <= `PRSEQ_INIT_SP;
            load_values.stat_word <= `PRSEQ_INIT_STAT_WORD;
         end
      end
   end

   // ----------------------------------------
   // interrupt pending latch
   // ----------------------------------------
   // a request beside its acknowledge survives; clear drops everything
   always_ff @(posedge sys_clk) begin
      if (sys_rst || is_clearing(next_state) || pwr_up_ff) begin
         irq_pend <= 4'h0;
         irq_to_core <= 4'h0;
      end else begin
         irq_pend <= (irq_pend & ~irq_ack) | irq_req;
         irq_to_core <= (irq_pend & ~irq_ack) | irq_req;
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         standalone <= 1'b0;
         start_addr <= `PRSEQ_START_RST;
      end else if (reg_wr && (reg_addr == `PRSEQ_REG_CTRL)) begin
         standalone <= reg_wdata[`PRSEQ_CTRL_STANDALONE];
      end else if (reg_wr && (reg_addr == `PRSEQ_REG_START)) begin
         start_addr <= reg_wdata;
      end
   end

   // power-up clears all four; the reset instruction clears only register D
   always_ff @(posedge sys_clk) begin
      if (sys_rst || (is_clearing(state) && pwr_up_ff)) begin
         csr_a <= `PRSEQ_CSR_RST;
         csr_b <= `PRSEQ_CSR_RST;
         csr_c <= `PRSEQ_CSR_RST;
         local_control_status_d <= `PRSEQ_CSR_RST;
      end else begin
         if (reg_wr && (reg_addr == `PRSEQ_REG_CSR_A)) begin
            csr_a <= reg_wdata;
         end
         if (reg_wr && (reg_addr == `PRSEQ_REG_CSR_B)) begin
            csr_b <= reg_wdata;
         end
         if (reg_wr && (reg_addr == `PRSEQ_REG_CSR_C)) begin
            csr_c <= reg_wdata;
         end
         if (state == prseq_pkg::ST_RST_CLEAR) begin
            local_control_status_d <= `PRSEQ_CSR_RST;
         end else if (reg_wr && (reg_addr == `PRSEQ_REG_LCS_D)) begin
            local_control_status_d <= reg_wdata;
         end
      end
   end

   // mode is sampled from the local bus as the reset instruction starts
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mode_reg <= `PRSEQ_MODE_RST;
      end else if ((state == prseq_pkg::ST_RUN) && (next_state == prseq_pkg::ST_RST_CLEAR)) begin
         mode_reg <= local_addr_data_bus;
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_comb begin
      status = '0;
      status.state = state;
      status.nop_count = nop_count;
      status.standalone = standalone;
      status.fetch_enable = fetch_enable;
      status.bus_clear = !bus_clear_output_n;
      status.power_up = pwr_up_ff;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || !reg_rd) begin
         reg_rdata <= 16'h0000;
      end else begin
         case (reg_addr)
            `PRSEQ_REG_CTRL: reg_rdata <= {15'h0000, standalone};
            `PRSEQ_REG_STATUS: reg_rdata <= status;
            `PRSEQ_REG_CSR_A: reg_rdata <= csr_a;
            `PRSEQ_REG_CSR_B: reg_rdata <= csr_b;
            `PRSEQ_REG_CSR_C: reg_rdata <= csr_c;
            `PRSEQ_REG_LCS_D: reg_rdata <= local_control_status_d;
            `PRSEQ_REG_MODE: reg_rdata <= mode_reg;
            `PRSEQ_REG_START: reg_rdata <= start_addr;
            default: reg_rdata <= 16'h0000;
         endcase
      end
   end

   assign power_up_input = pwr_up_ff;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   int unsigned supply_cycles;

   // length of the current unbroken stretch of supply
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !supply_good) begin
         supply_cycles <= 0;
      end else if (supply_cycles < 32'hffff_ffff) begin
         supply_cycles <= supply_cycles + 1;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   property p_pwr_delay;
      (state == prseq_pkg::ST_PWR_DELAY) && (next_state == prseq_pkg::ST_CLEAR_WAIT)
         |-> supply_cycles >= PWR_DELAY_CYCLES;
   endproperty
   a_pwr_delay: assert property (p_pwr_delay) else $error("sequence began early");

   property p_clear_follows;
      $rose(state == prseq_pkg::ST_CLEAR_WAIT) |-> !bus_clear_output_n && !backplane_xcvr_en;
   endproperty
   a_clear_follows: assert property (p_clear_follows) else $error("bus clear missing");

   property p_periph_release;
      $fell(pwr_up_ff) && !standalone |-> $past(!dc_ok_n && !power_ok_n, 2);
   endproperty
   a_periph_release: assert property (p_periph_release) else $error("release without ok");

   property p_standalone_release;
      $fell(pwr_up_ff) && standalone |-> $past(!power_up_trigger_n);
   endproperty
   a_standalone_release: assert property (p_standalone_release) else $error("no trigger");

   property p_ten_nops;
      $rose(state == prseq_pkg::ST_LOAD) |-> nop_count == `PRSEQ_NOP_COUNT;
   endproperty
   a_ten_nops: assert property (p_ten_nops) else $error("load before ten no-ops");

   property p_load_values;
      load_regs |-> (load_values.sp == `PRSEQ_INIT_SP) && (load_values.pc == start_addr)
                    && (load_values.stat_word == `PRSEQ_INIT_STAT_WORD);
   endproperty
   a_load_values: assert property (p_load_values) else $error("wrong initial values");

   property p_pi_before_fetch;
      $rose(fetch_enable) |-> $past(priority_in_strobe) && $past(assert_priority_in_cycle);
   endproperty
   a_pi_before_fetch: assert property (p_pi_before_fetch) else $error("fetch without pi");

   property p_xcvr_off;
      !bus_clear_output_n |-> !backplane_xcvr_en && !local_xcvr_en && (irq_to_core == 4'h0);
   endproperty
   a_xcvr_off: assert property (p_xcvr_off) else $error("live path under clear");

   property p_reset_reg_d;
      (state == prseq_pkg::ST_RST_CLEAR) |=> (local_control_status_d == `PRSEQ_CSR_RST);
   endproperty
   a_reset_reg_d: assert property (p_reset_reg_d) else $error("register D kept");

   property p_reset_to_pi;
      (state == prseq_pkg::ST_RST_CLEAR) && !power_up_force ##1 bus_clear_output_n
         |-> assert_priority_in_cycle && !load_regs;
   endproperty
   a_reset_to_pi: assert property (p_reset_to_pi) else $error("no pi after reset");

   property p_clear_cause;
      !bus_clear_output_n |-> pwr_up_ff || (state == prseq_pkg::ST_RST_CLEAR);
   endproperty
   a_clear_cause: assert property (p_clear_cause) else $error("stray bus clear");

   c_power_up_run: cover property ($rose(fetch_enable) && !standalone);
   c_standalone_run: cover property ($rose(fetch_enable) && standalone);
   c_reset_instr: cover property ((state == prseq_pkg::ST_RST_CLEAR) ##1 bus_clear_output_n);
   c_forced: cover property (txn_abort);

endmodule

`default_nettype wire

// ==== prseq_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// core-side stand-in
// ----------------------------------------
// PERIOD stretches the microcycle to act as a slow core
module prseq_core_model #(
   parameter int PERIOD = 4,
   parameter logic [15:0] MODE_CFG = 16'h00a5
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   output logic clock_out_strobe,
   output logic [15:0] local_addr_data_bus
);
   logic [3:0] phase;
   // one clock-out pulse per microcycle, silent in reset
   always_ff @(posedge sys_clk) begin
      phase <= (sys_rst || phase == 4'(PERIOD - 1)) ? 4'h0 : phase + 4'h1;
      clock_out_strobe <= !sys_rst && phase == 4'(PERIOD - 1);
   end
   // mode configuration word stays on the bus for the reload
   assign local_addr_data_bus = MODE_CFG;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "prseq_regs.svh"
// ----------------------------------------
// bench
// ----------------------------------------
module tb_top;
   logic sys_clk, sys_rst, reg_wr, reg_rd, supply_good, dc_ok_n, power_ok_n;
   logic power_up_trigger_n, power_up_force, clock_out_strobe, reset_instr;
   logic power_up_input, bus_clear_output_n, serial_line_clear, backplane_xcvr_en;
   logic local_xcvr_en, nop_cycle, load_regs, assert_priority_in_cycle;
   logic priority_in_strobe, fetch_enable, txn_abort, pi_seen;
   logic [2:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, local_addr_data_bus, mode_reg, d;
   logic [3:0] irq_req, irq_ack, irq_to_core;
   prseq_pkg::prseq_load_t load_values, load_cap;
   int fail_count, total_checks, n, nop_seen, load_cnt, lc;

   prseq_sequencer #(.PWR_DELAY_CYCLES(20)) prseq_sequencer_i (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .supply_good(supply_good), .dc_ok_n(dc_ok_n),
      .power_ok_n(power_ok_n), .power_up_trigger_n(power_up_trigger_n),
      .power_up_force(power_up_force), .clock_out_strobe(clock_out_strobe),
      .reset_instr(reset_instr), .local_addr_data_bus(local_addr_data_bus),
      .irq_req(irq_req), .irq_ack(irq_ack), .power_up_input(power_up_input),
      .bus_clear_output_n(bus_clear_output_n), .serial_line_clear(serial_line_clear),
      .backplane_xcvr_en(backplane_xcvr_en), .local_xcvr_en(local_xcvr_en),
      .irq_to_core(irq_to_core), .nop_cycle(nop_cycle), .load_regs(load_regs),
      .load_values(load_values), .assert_priority_in_cycle(assert_priority_in_cycle),
      .priority_in_strobe(priority_in_strobe), .fetch_enable(fetch_enable),
      .txn_abort(txn_abort), .mode_reg(mode_reg));
   prseq_core_model prseq_core_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .clock_out_strobe(clock_out_strobe), .local_addr_data_bus(local_addr_data_bus));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // tally no-op strobes and captured loads; note any priority-in pulse
   always @(posedge sys_clk) begin
      if (nop_cycle && clock_out_strobe) nop_seen <= nop_seen + 1;
      if (load_regs) load_cap <= load_values;
      if (load_regs) load_cnt <= load_cnt + 1;
      if (priority_in_strobe) pi_seen <= 1'b1;
   end

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic wait_fetch;
      for (int i = 0; i < 400 && fetch_enable !== 1'b1; i++) @(posedge sys_clk);
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // whole run needs about 3000 cycles; allow several times that
   initial begin
      #(40 * 20000);
      fail_count++;
      complete_run;
   end

   initial begin
      {sys_rst, supply_good, dc_ok_n, power_ok_n, power_up_trigger_n} = 5'h1f;
      {reg_wr, reg_rd, power_up_force, reset_instr, pi_seen} = 5'h00;
      {reg_addr, reg_wdata, irq_req, irq_ack} = '0;
      {nop_seen, load_cnt} = '0;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      #1 check({bus_clear_output_n, power_up_input, fetch_enable}, 3'b110);
      wr(`PRSEQ_REG_START, 16'h2000);
      for (n = 0; n < 100 && bus_clear_output_n !== 1'b0; n++) begin
         @(posedge sys_clk);
         #1;
      end
      // 20-cycle supply delay plus one cycle to leave the state, less the two cycles spent in the write above
      check(n, 19);
      check(bus_clear_output_n, 1'b0);
      dc_ok_n <= 1'b0;
      power_ok_n <= 1'b0;
      repeat (2000) @(posedge sys_clk);
      #1 check(power_up_input, 1'b1);
      for (n = 0; n < 600 && power_up_input !== 1'b0; n++) @(posedge sys_clk);
      #1 check({power_up_input, bus_clear_output_n}, 2'b01);
      wait_fetch;
      check(nop_seen, 10);
      check(load_cap, {16'h2000, `PRSEQ_INIT_SP, `PRSEQ_INIT_STAT_WORD});
      check({pi_seen, bus_clear_output_n}, 2'b11);
      $display("test peripheral power-up done");
      // a pending request must be dropped by the reset instruction
      irq_req <= 4'h1;
      @(posedge sys_clk);
      irq_req <= 4'h0;
      repeat (2) @(posedge sys_clk);
      #1 check(irq_to_core, 4'h1);
      // a new request beside an acknowledge of the old one: the set wins
      irq_ack <= 4'h1;
      irq_req <= 4'h3;
      @(posedge sys_clk);
      irq_ack <= 4'h0;
      irq_req <= 4'h0;
      #1 check(irq_to_core, 4'h3);
      wr(`PRSEQ_REG_LCS_D, 16'hffff);
      wr(`PRSEQ_REG_CSR_A, 16'h5a5a);
      pi_seen = 1'b0;
      lc = load_cnt;
      @(posedge sys_clk);
      reset_instr <= 1'b1;
      @(posedge sys_clk);
      reset_instr <= 1'b0;
      #1 check({bus_clear_output_n, backplane_xcvr_en, local_xcvr_en}, 3'b000);
      check(irq_to_core, 4'h0);
      check(mode_reg, 16'h00a5);
      // clear stands from the taking edge through ten more timer counts
      repeat (10) @(posedge sys_clk);
      #1 check(bus_clear_output_n, 1'b0);
      @(posedge sys_clk);
      #1 check({bus_clear_output_n, assert_priority_in_cycle}, 2'b11);
      wait_fetch;
      check({pi_seen, irq_to_core, backplane_xcvr_en, local_xcvr_en}, 7'h43);
      check(load_cnt, lc);
      rd(`PRSEQ_REG_LCS_D, d);
      check(d, 16'h0000);
      rd(`PRSEQ_REG_CSR_A, d);
      check(d, 16'h5a5a);
      $display("test reset instruction done");
      // standalone restart by a forced power-up
      wr(`PRSEQ_REG_CTRL, 16'h0001);
      dc_ok_n <= 1'b1;
      power_ok_n <= 1'b1;
      nop_seen = 0;
      @(posedge sys_clk);
      power_up_force <= 1'b1;
      @(posedge sys_clk);
      power_up_force <= 1'b0;
      #1 check({txn_abort, power_up_input, bus_clear_output_n, irq_to_core}, 7'h60);
      check(serial_line_clear, 1'b1);
      rd(`PRSEQ_REG_CSR_A, d);
      check(d, 16'h0000);
      repeat (50) @(posedge sys_clk);
      #1 check(power_up_input, 1'b1);
      @(posedge sys_clk);
      power_up_trigger_n <= 1'b0;
      @(posedge sys_clk);
      power_up_trigger_n <= 1'b1;
      for (n = 0; n < 3 && power_up_input !== 1'b0; n++) @(posedge sys_clk);
      #1 check(power_up_input, 1'b0);
      wait_fetch;
      check(nop_seen, 10);
      check(load_cnt, lc + 1);
      $display("test standalone restart done");
      // software reset through the control register keeps the standalone bit
      wr(`PRSEQ_REG_CTRL, 16'h0003);
      #1 check(bus_clear_output_n, 1'b0);
      wait_fetch;
      check(load_cnt, lc + 1);
      rd(`PRSEQ_REG_STATUS, d);
      check(d, 16'h60c0);
      $display("test software reset done");
      complete_run;
   end
endmodule
`default_nettype wire
